// ===== inc/itt_cfg.svh
`ifndef ITT_CFG_SVH
`define ITT_CFG_SVH

// register byte offsets
`define ITT_CTRL_OFF      8'h00
`define ITT_TIMER_OFF     8'h04
`define ITT_STAT_OFF      8'h08

// control register bit positions
`define ITT_CTRL_DIS_BIT  0
`define ITT_CTRL_F50_BIT  1

// status register bit positions
`define ITT_STAT_HOLD_BIT 4
`define ITT_STAT_CLR_BIT  5
`define ITT_STAT_DRV_BIT  6
`define ITT_STAT_BUSY_BIT 7

// tick counter limits
`define ITT_CNT_EMPTY     4'h0
`define ITT_CNT_FULL      4'hf
`define ITT_CNT_ONE       4'h1

// multipliers for 60-cycle and 50-cycle mains
`define ITT_MUL60         7'h05
`define ITT_MUL50         7'h06

// timer word layout: sign bit over 23 count bits
`define ITT_SIGN_BIT      23
`define ITT_TIMER_RST     24'h000000

`endif

// ===== inc/itt_pkg.sv
package itt_pkg;

  // update sequencer states, gray coded along the usual path
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_take = 2'b01,
    st_sub  = 2'b11,
    st_fin  = 2'b10
  } itt_state_t;

  // one register bus request, sampled on a rising edge
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } itt_bus_req_t;

endpackage : itt_pkg

// ===== tb/itt_seq_model.sv
`timescale 1ns/10ps
// processor side: T-pulse ring and the mains pulse source
module itt_seq_model (
  input  wire logic clk_sys,            // system clock
  input  wire logic rst_b,              // synchronous, active low
  output logic      third_timing_pulse, // one cycle in four
  output logic      t4_pulse,           // follows the third pulse
  output logic      line_pulse          // mains pulse, level
);
  logic [1:0] phase; // position within the processor cycle

  // free-running ring; third and fourth pulses never overlap
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign third_timing_pulse = (phase == 2'h2);
  assign t4_pulse           = (phase == 2'h3);

  initial line_pulse = 1'b0;

  // each pulse and its gap span two third-pulse slots, so none slips past the latch
  task automatic give_ticks(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys);
      line_pulse <= 1'b1;
      repeat (4) @(posedge clk_sys);
      line_pulse <= 1'b0;
    end
    repeat (8) @(posedge clk_sys); // let the last count land
  endtask : give_ticks
endmodule : itt_seq_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`include "itt_cfg.svh"
module tb_top;
  // one update case: stimulus beside the result it should give
  typedef struct packed {
    logic [4:0]  ticks; // mains pulses given
    logic        f50;   // 50-cycle mode
    logic [23:0] init;  // timer before update
    logic [3:0]  cnt;   // count held at update
    logic [23:0] res;   // timer after update
    logic        irq;   // sign change expected
  } itt_row_t;

  logic                  clk_sys  = 1'b0; // 20 MHz
  logic                  rst_b    = 1'b0; // held for two cycles
  logic                  exec_end = 1'b0; // execute phase end
  itt_pkg::itt_bus_req_t bus_req  = '0;   // register bus request
  logic                  third_timing_pulse;
  logic                  t4_pulse;
  logic                  line_pulse;
  logic [31:0]           bus_rdata;
  logic [31:0]           rd;              // last read value
  logic                  update_req;
  logic                  ext_irq;
  logic                  ifetch_go;
  int                    mismatches = 0;
  int                    checks = 0;
  int                    cycles = 0;
  logic [31:0]           upd_n = '0, irq_n = '0, go_n = '0; // seen
  logic [31:0]           eu = '0, ei = '0, eg = '0;         // expected
  itt_row_t              rows [5];

  always #25 clk_sys = ~clk_sys;

  itt_seq_model itt_seq_model_i (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .third_timing_pulse (third_timing_pulse),
    .t4_pulse           (t4_pulse),
    .line_pulse         (line_pulse)
  );

  itt_tick_update itt_tick_update_i (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .line_pulse         (line_pulse),
    .third_timing_pulse (third_timing_pulse),
    .t4_pulse           (t4_pulse),
    .exec_end           (exec_end),
    .bus_req            (bus_req),
    .bus_rdata          (bus_rdata),
    .update_req         (update_req),
    .ext_irq            (ext_irq),
    .ifetch_go          (ifetch_go)
  );

  // pulses are counted, so a missing or doubled one shows up
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (update_req === 1'b1) upd_n <= upd_n + 1;
    if (ext_irq === 1'b1) irq_n <= irq_n + 1;
    if (ifetch_go === 1'b1) go_n <= go_n + 1;
    if (cycles == 4000) begin // run takes about 600 cycles
      mismatches++;
      end_sim;
    end
  end

  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd   <= 1'b0;
    #1 rd = bus_rdata;
  endtask : rdr

  // update finishes three cycles after the pulse; wait a margin
  task automatic exec_pulse;
    @(posedge clk_sys);
    exec_end <= 1'b1;
    @(posedge clk_sys);
    exec_end <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : exec_pulse

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    // row 0 has no pulses: the one left pending while disabled counts
    rows[0] = '{5'h00, 1'b0, 24'h000064, 4'h1, 24'h00005f, 1'b0};
    rows[1] = '{5'h0f, 1'b0, 24'h0003e8, 4'hf, 24'h00039d, 1'b0};
    rows[2] = '{5'h11, 1'b1, 24'h0003e8, 4'hf, 24'h00038e, 1'b0};
    rows[3] = '{5'h03, 1'b0, 24'h00000a, 4'h3, 24'hfffffb, 1'b1};
    rows[4] = '{5'h02, 1'b1, 24'h800005, 4'h2, 24'h7ffff9, 1'b1};
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdr(`ITT_CTRL_OFF);
    cmp("ctrl", 32'h00000001, rd);
    rdr(`ITT_TIMER_OFF);
    cmp("timer", 32'h00000000, rd);
    rdr(8'h0c);
    cmp("unmapped", 32'h00000000, rd);
    // disabled after reset: pulses must not count
    itt_seq_model_i.give_ticks(2);
    rdr(`ITT_STAT_OFF);
    cmp("status", 32'h00000010, {24'h0, rd[7:0]});
    exec_pulse;
    cmp("update", eu, upd_n);
    for (int i = 0; i < 5; i++) begin
      wr(`ITT_TIMER_OFF, {8'h0, rows[i].init});
      wr(`ITT_CTRL_OFF, {30'h0, rows[i].f50, 1'b0});
      repeat (16) @(posedge clk_sys);
      itt_seq_model_i.give_ticks(int'(rows[i].ticks));
      rdr(`ITT_STAT_OFF);
      cmp("count", {28'h0, rows[i].cnt}, {28'h0, rd[3:0]});
      cmp("latches", 32'h0, {29'h0, rd[6:4]});
      exec_pulse;
      eu = eu + 1;
      if (rows[i].irq) begin
        ei = ei + 1;
      end else begin
        eg = eg + 1;
      end
      cmp("update", eu, upd_n);
      cmp("irq", ei, irq_n);
      cmp("fetch", eg, go_n);
      rdr(`ITT_TIMER_OFF);
      cmp("timer", {8'h0, rows[i].res}, rd);
      rdr(`ITT_STAT_OFF);
      cmp("cleared", 32'h0, {28'h0, rd[3:0]});
    end
    // mode readback, then read data must fall back to zero
    rdr(`ITT_CTRL_OFF);
    cmp("ctrl f50", 32'h00000002, rd);
    @(posedge clk_sys);
    #1;
    cmp("rdata idle", 32'h00000000, bus_rdata);
    // a busy update refuses a timer preset and a second request
    wr(`ITT_TIMER_OFF, 32'h00000100);
    itt_seq_model_i.give_ticks(2);
    @(posedge clk_sys);
    exec_end      <= 1'b1;
    @(posedge clk_sys);
    bus_req.addr  <= `ITT_TIMER_OFF;
    bus_req.wdata <= 32'h00000555;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys);
    exec_end      <= 1'b0;
    bus_req.wr    <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    eu = eu + 1;
    eg = eg + 1;
    cmp("update", eu, upd_n);
    cmp("irq", ei, irq_n);
    cmp("fetch", eg, go_n);
    rdr(`ITT_TIMER_OFF);
    cmp("timer busy", 32'h000000f4, rd);
    // reset in mid-run puts every register back to its start value
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdr(`ITT_CTRL_OFF);
    cmp("ctrl reset", 32'h00000001, rd);
    rdr(`ITT_TIMER_OFF);
    cmp("timer reset", 32'h00000000, rd);
    rdr(`ITT_STAT_OFF);
    cmp("status reset", 32'h00000010, rd);
    end_sim;
  end
endmodule : tb_top

// ===== verilog/itt_tick_update.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "itt_cfg.svh"
// Behaviour
// - counter advances only from line-frequency pulses
// - four-bit counter, full after fifteen pulses
// - request update at execute end if nonzero
// - 60-cycle: multiply count by five, subtract
// - sign change of timer raises external interrupt
// - no sign change: return to instruction fetch
// - counting blocked while hold latch set
// - disable off: clear latch set at T4
// - clear latch drops hold; hold drop frees it
// - hold off: line pulse sets drive latch
// - drive latch gives one count per pulse
// - taking count sets hold, resets counter
// - 50-cycle: multiply count by six instead
// - 300 subtracted per second either way
// - timer word: sign bit plus 23 bits
module itt_tick_update (
  input  wire logic                 clk_sys,     // 20 MHz system clock
  input  wire logic                 rst_b,       // synchronous, active low
  input  wire logic                 line_pulse,  // mains frequency pulse
  input  wire logic                 third_timing_pulse, // third pulse
  input  wire logic                 t4_pulse,    // processor T4
  input  wire logic                 exec_end,    // end of execute phase
  input  wire itt_pkg::itt_bus_req_t bus_req,    // register bus request
  output logic [31:0]               bus_rdata,   // read data, next cycle
  output logic                      update_req,  // update routine entered
  output logic                      ext_irq,     // external interrupt
  output logic                      ifetch_go    // resume instruction fetch
);

  // software control bits
  logic                 timer_disable;    // timer-disable switch
  logic                 fifty_cycle;      // 50-cycle mains machine
  // timer word and tick logic
  logic [23:0]          timer_word;       // signed timer word
  logic [3:0]           tick_cnt;         // tick counter
  logic                 hold_latch;       // governing hold latch
  logic                 counter_clear_latch; // drives counter reset
  logic                 drive_latch;      // one count pulse
  logic                 line_prev;        // last line pulse level
  logic                 line_seen;        // captured line pulse
  logic [6:0]           mult_prod;        // count times multiplier
  itt_pkg::itt_state_t  state;            // update sequencer
  // combinational helpers
  logic                 line_rise;        // new mains pulse
  logic                 start_upd;        // update begins
  logic [6:0]           mul_sel;          // chosen multiplier
  logic [23:0]          next_timer;       // timer after subtraction
  logic                 sign_flip;        // subtraction changed sign

  // address decode, used for both reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign line_rise  = line_pulse & ~line_prev;
  // update starts only from idle so a second request cannot overlap
  assign start_upd  = exec_end & (tick_cnt != `ITT_CNT_EMPTY) &
                      (state == itt_pkg::st_idle);
  // five per sixtieth or six per fiftieth both make 300 a second
  assign mul_sel    = fifty_cycle ? `ITT_MUL50 : `ITT_MUL60;
  assign next_timer = timer_word - {17'h00000, mult_prod};
  assign sign_flip  = next_timer[`ITT_SIGN_BIT] !=
                      timer_word[`ITT_SIGN_BIT];

  // control register: software steers disable and mains rate
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      timer_disable <= 1'b1;
      fifty_cycle   <= 1'b0;
    end else if (bus_req.wr && hit(bus_req.addr, `ITT_CTRL_OFF)) begin
      timer_disable <= bus_req.wdata[`ITT_CTRL_DIS_BIT];
      fifty_cycle   <= bus_req.wdata[`ITT_CTRL_F50_BIT];
    end
  end

  // timer word: the update routine owns it while it runs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      timer_word <= `ITT_TIMER_RST;
    end else if (state == itt_pkg::st_sub) begin
      timer_word <= next_timer;
    end else if (bus_req.wr && hit(bus_req.addr, `ITT_TIMER_OFF)) begin
      // software preset is dropped during an update to keep it atomic
      if (state == itt_pkg::st_idle) begin
        timer_word <= bus_req.wdata[23:0];
      end
    end
  end

  // read data stands in the cycle after the read strobe only
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_req.rd) begin
      bus_rdata <= 32'h00000000;
      if (hit(bus_req.addr, `ITT_CTRL_OFF)) begin
        bus_rdata[`ITT_CTRL_DIS_BIT] <= timer_disable;
        bus_rdata[`ITT_CTRL_F50_BIT] <= fifty_cycle;
      end else if (hit(bus_req.addr, `ITT_TIMER_OFF)) begin
        bus_rdata[23:0] <= timer_word;
      end else if (hit(bus_req.addr, `ITT_STAT_OFF)) begin
        bus_rdata[3:0]                <= tick_cnt;
        bus_rdata[`ITT_STAT_HOLD_BIT] <= hold_latch;
        bus_rdata[`ITT_STAT_CLR_BIT]  <= counter_clear_latch;
        bus_rdata[`ITT_STAT_DRV_BIT]  <= drive_latch;
        bus_rdata[`ITT_STAT_BUSY_BIT] <= (state != itt_pkg::st_idle);
      end
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

  // clear latch: armed at T4 while hold is set, freed when hold drops
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      counter_clear_latch <= 1'b0;
    end else if (!hold_latch) begin
      counter_clear_latch <= 1'b0;
    end else if (t4_pulse && !timer_disable) begin
      counter_clear_latch <= 1'b1;
    end
  end

  // hold latch: starts set, cleared by the clear latch on the third pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hold_latch <= 1'b1;
    end else if (state == itt_pkg::st_take) begin
      hold_latch <= 1'b1;
    end else if (counter_clear_latch && third_timing_pulse) begin
      hold_latch <= 1'b0;
    end
  end

  // line pulse capture: a new pulse wins over its own consumption
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      line_prev <= 1'b0;
      line_seen <= 1'b0;
    end else begin
      line_prev <= line_pulse;
      if (line_rise) begin
        line_seen <= 1'b1;
      end else if (drive_latch) begin
        line_seen <= 1'b0;
      end
    end
  end

  // drive latch: one cycle long, so no pulse counts more than once
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drive_latch <= 1'b0;
    end else if (drive_latch) begin
      drive_latch <= 1'b0;
    end else begin
      drive_latch <= line_seen & ~hold_latch & third_timing_pulse;
    end
  end

  // tick counter: resets win, saturates at full instead of wrapping
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tick_cnt <= `ITT_CNT_EMPTY;
    end else if (counter_clear_latch || state == itt_pkg::st_take) begin
      tick_cnt <= `ITT_CNT_EMPTY;
    end else if (drive_latch && !hold_latch) begin
      if (tick_cnt != `ITT_CNT_FULL) begin
        tick_cnt <= tick_cnt + `ITT_CNT_ONE;
      end else begin
        tick_cnt <= tick_cnt;
      end
    end
  end

  // multiplier operand: count taken and scaled in the take state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mult_prod <= 7'h00;
    end else if (state == itt_pkg::st_take) begin
      mult_prod <= 7'({3'h0, tick_cnt} * mul_sel);
    end
  end

  // update sequencer: take, subtract, then interrupt or return
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= itt_pkg::st_idle;
    end else begin
      case (state)
        itt_pkg::st_idle: begin
          if (start_upd) begin
            state <= itt_pkg::st_take;
          end
        end
        itt_pkg::st_take: begin
          state <= itt_pkg::st_sub;
        end
        itt_pkg::st_sub: begin
          state <= itt_pkg::st_fin;
        end
        itt_pkg::st_fin: begin
          state <= itt_pkg::st_idle;
        end
        default: begin
          state <= itt_pkg::st_idle;
        end
      endcase
    end
  end

  // outward pulses, all straight from flip-flops
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      update_req <= 1'b0;
      ext_irq    <= 1'b0;
      ifetch_go  <= 1'b0;
    end else begin
      update_req <= start_upd;
      ext_irq    <= (state == itt_pkg::st_sub) & sign_flip;
      ifetch_go  <= (state == itt_pkg::st_sub) & ~sign_flip;
    end
  end

  // checks on the running logic
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_take_sub;
    (state == itt_pkg::st_take) ##1 (state == itt_pkg::st_sub);
  endsequence

  sequence s_req_walk;
    start_upd ##1 update_req ##1 (state == itt_pkg::st_sub);
  endsequence

  property p_req_path;
    start_upd |-> s_req_walk ##1 (ext_irq || ifetch_go);
  endproperty
  a_req_path: assert property (p_req_path)
    else $error("update request did not run to completion");

  property p_mult;
    (state == itt_pkg::st_take) |=>
      mult_prod == 7'({3'h0, $past(tick_cnt)} * $past(mul_sel));
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier product wrong");

  property p_mult50;
    (state == itt_pkg::st_take && fifty_cycle && tick_cnt == `ITT_CNT_FULL)
      |=> mult_prod == 7'h5a;
  endproperty
  a_mult50: assert property (p_mult50)
    else $error("full count on 50-cycle must give 90");

  property p_sub;
    s_take_sub |=> timer_word == $past(timer_word) - {17'h0, $past(mult_prod)};
  endproperty
  a_sub: assert property (p_sub)
    else $error("timer not reduced by product");

  property p_irq;
    (state == itt_pkg::st_sub) |=>
      (ext_irq == (timer_word[`ITT_SIGN_BIT] !=
                   $past(timer_word[`ITT_SIGN_BIT]))) && !update_req;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not match sign change");

  property p_ret;
    (state == itt_pkg::st_fin) |-> (ext_irq ^ ifetch_go);
  endproperty
  a_ret: assert property (p_ret)
    else $error("finish must give exactly one exit");

  property p_hold_block;
    (hold_latch && !counter_clear_latch && state != itt_pkg::st_take)
      |=> tick_cnt == $past(tick_cnt);
  endproperty
  a_hold_block: assert property (p_hold_block)
    else $error("counter moved while hold set");

  property p_clear_set;
    (t4_pulse && !timer_disable && hold_latch) |=> counter_clear_latch;
  endproperty
  a_clear_set: assert property (p_clear_set)
    else $error("clear latch not set at T4");

  property p_no_clear;
    (timer_disable && !counter_clear_latch) |=> !counter_clear_latch;
  endproperty
  a_no_clear: assert property (p_no_clear)
    else $error("clear latch set while disabled");

  property p_hold_off;
    (counter_clear_latch && third_timing_pulse &&
     state != itt_pkg::st_take) |=> !hold_latch ##1 !counter_clear_latch;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("hold or clear latch sequence wrong");

  property p_drive_one;
    drive_latch |=> !drive_latch;
  endproperty
  a_drive_one: assert property (p_drive_one)
    else $error("drive latch longer than one cycle");

  property p_count_src;
    (tick_cnt != $past(tick_cnt) && tick_cnt != `ITT_CNT_EMPTY)
      |-> $past(drive_latch) && $past(tick_cnt) + `ITT_CNT_ONE == tick_cnt;
  endproperty
  a_count_src: assert property (p_count_src)
    else $error("counter moved without a drive pulse");

  property p_saturate;
    (tick_cnt == `ITT_CNT_FULL && !counter_clear_latch &&
     state != itt_pkg::st_take) |=> tick_cnt == `ITT_CNT_FULL;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("full counter wrapped");

  property p_take_reset;
    (state == itt_pkg::st_take) |=> hold_latch && tick_cnt == `ITT_CNT_EMPTY;
  endproperty
  a_take_reset: assert property (p_take_reset)
    else $error("take did not set hold and reset counter");

  // a pending tick with hold off must arm the drive latch at once
  property p_drive_set;
    (line_seen && !hold_latch && third_timing_pulse && !drive_latch)
      |=> drive_latch;
  endproperty
  a_drive_set: assert property (p_drive_set)
    else $error("drive latch not set by pending tick");

  // every drive pulse below full, outside take and clear, adds exactly one to the counter
  property p_count_step;
    (drive_latch && !hold_latch && !counter_clear_latch &&
     state != itt_pkg::st_take && tick_cnt != `ITT_CNT_FULL)
      |=> tick_cnt == $past(tick_cnt) + `ITT_CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step on drive pulse");

endmodule : itt_tick_update
